// ### inc/sfc_pkg.sv
/*
  Shared constants and types for the synchrophasor frame content block.
  Assumes a 100 MHz system clock; all counts are derived from that rate.
*/
package sfc_pkg;
  // Phasor set selection codes.
  typedef enum logic [1:0] {
    SFC_PH_NONE = 2'h0,
    SFC_PH_POS = 2'h1,
    SFC_PH_ALL = 2'h2
  } sfc_phsel_type;
  // Frame rate selection: frames per second.
  typedef enum logic [1:0] {
    SFC_RATE_1 = 2'h0,
    SFC_RATE_2 = 2'h1,
    SFC_RATE_5 = 2'h2,
    SFC_RATE_10 = 2'h3
  } sfc_rate_type;
  // Time code control extension handling.
  typedef enum logic {
    SFC_TEXT_NONE = 1'h0,
    SFC_TEXT_STD = 1'h1
  } sfc_text_type;
  // Emission states, Gray coded along the frame path.
  typedef enum logic [2:0] {
    SFC_IDLE = 3'h0,
    SFC_HEAD = 3'h1,
    SFC_PHAS = 3'h3,
    SFC_FREQ = 3'h2,
    SFC_ANLG = 3'h6,
    SFC_STAT = 3'h7,
    SFC_CRC = 3'h5
  } sfc_state_type;
  // Clock period and frame base period, in nanoseconds.
  localparam int SFC_CLK_NS = 10;
  localparam int SFC_BASE_NS = 100_000_000;
  localparam int SFC_BASE_CYCLES = SFC_BASE_NS / SFC_CLK_NS;
  // Frame trigger hold time after a reason change, in nanoseconds.
  localparam int SFC_HOLD_NS = 200_000_000;
  localparam int SFC_HOLD_CYCLES = SFC_HOLD_NS / SFC_CLK_NS;
  // Base periods per frame for each rate (1, 2, 5, 10 per second).
  localparam logic [3:0] SFC_DIV_1 = 4'hA;
  localparam logic [3:0] SFC_DIV_2 = 4'h5;
  localparam logic [3:0] SFC_DIV_5 = 4'h2;
  localparam logic [3:0] SFC_DIV_10 = 4'h1;
  // Frame layout.
  localparam logic [15:0] SFC_SYNC_WORD = 16'hAA01;
  localparam logic [15:0] SFC_FIXED_BYTES = 16'h0012;
  localparam logic [15:0] SFC_FREQ_BYTES = 16'h0004;
  localparam logic [15:0] SFC_PH_BYTES = 16'h0004;
  localparam logic [15:0] SFC_AN_BYTES = 16'h0004;
  localparam logic [15:0] SFC_DSW_BYTES = 16'h0002;
  localparam logic [3:0] SFC_HEAD_LAST = 4'h7;
  localparam logic [3:0] SFC_PH_COUNT = 4'hA;
  localparam logic [3:0] SFC_PH_V_COUNT = 4'h5;
  localparam logic [3:0] SFC_PH_SYNC_IDX = 4'h4;
  localparam logic [3:0] SFC_PH_I_POS_IDX = 4'h5;
  localparam logic [2:0] SFC_AN_MAX = 3'h4;
  // Status word field positions.
  localparam int SFC_STAT_SYNC_ERR = 13;
  localparam int SFC_STAT_TRIG = 11;
  // Angle limits in hundredths of a degree.
  localparam logic signed [16:0] SFC_ANG_HALF = 17'sh0_4650;
  localparam logic signed [16:0] SFC_ANG_FULL = 17'sh0_8CA0;
  // Check value generator.
  localparam logic [15:0] SFC_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] SFC_CRC_POLY = 16'h1021;
endpackage

// ### inc/sfc_stream_if.sv
/*
  Valid/ready word stream between the framer and its FIFO.
  Assumes one clock shared by both ends.
*/
interface sfc_stream_if #(parameter int W = 17);
  logic valid; // Word offered.
  logic ready; // Word accepted when both are high.
  logic [W-1:0] data; // Word content.
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### logic/sfc_fifo.sv
/*
  Word FIFO with parameter width and depth and valid/ready on both sides.
  Assumes a single clock and an active low asynchronous reset.
*/
module sfc_fifo #(
  parameter int W = 17,
  parameter int D = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling and draining sides.
  sfc_stream_if.snk in_s,
  sfc_stream_if.src out_s
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D]; // Storage.
  logic [AW:0] cnt_ff, nxt_cnt; // Occupancy.
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd; // Pointers.
  logic push, pop;

  // Full and empty come straight from the occupancy count.
  assign in_s.ready = (cnt_ff != D[AW:0]);
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data = mem_ff[rd_ff];

  // Pointer and count update.
  always_comb begin
    push = in_s.valid && in_s.ready;
    pop = out_s.valid && out_s.ready;
    nxt_wr = push ? ((wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
    nxt_rd = pop ? ((rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // Storage has no reset; only valid entries are ever read out.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end
endmodule // sfc_fifo

// ### logic/sfc_framer.sv
/*
  Synchrophasor data frame content: selection, ordering and framing of the
  words streamed to a data concentrator, plus time and trigger flags.
  Assumes a serialiser downstream that drains FRAME_WORD under FRAME_READY.
*/
module sfc_framer
  import sfc_pkg::*;
#(
  parameter int BASE_CYCLES = sfc_pkg::SFC_BASE_CYCLES,
  parameter int HOLD_CYCLES = sfc_pkg::SFC_HOLD_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Settings.
  input wire logic [127:0] STATION_NAME,
  input wire logic [15:0] UNIT_IDENTIFIER,
  input wire sfc_pkg::sfc_phsel_type VOLTAGE_PHASOR_SELECT,
  input wire sfc_pkg::sfc_phsel_type CURRENT_PHASOR_SELECT,
  input wire logic signed [15:0] VOLTAGE_ANGLE_OFFSET,
  input wire logic signed [15:0] CURRENT_ANGLE_OFFSET,
  input wire logic [2:0] ANALOG_VALUE_COUNT,
  input wire logic STATUS_WORD_COUNT,
  input wire sfc_pkg::sfc_rate_type FRAME_RATE_SELECT,
  input wire sfc_pkg::sfc_text_type TIME_EXTENSION_SELECT,
  input wire logic SYNCHROPHASOR_GLOBAL_ENABLE,
  input wire logic DEVICE_ENABLED,
  // Measurements, on this clock.
  input wire logic [9:0][15:0] PHASOR_MAG,
  input wire logic [9:0][15:0] PHASOR_ANG,
  input wire logic SYNC_INPUT_PRESENT,
  input wire logic [15:0] FREQ_DEVIATION,
  input wire logic [15:0] FREQ_RATE,
  input wire logic [3:0][31:0] ANALOG_SLOT,
  input wire logic [15:0] STATUS_SOURCE,
  // Trigger equation operands and masks, on this clock.
  input wire logic [3:0][15:0] TRIGGER_TERMS,
  input wire logic [3:0][15:0] TRIGGER_MASK,
  // Time source.
  input wire logic EXT_TIME_LOCK,
  input wire logic EXT_TIME_ACCURATE,
  input wire logic [31:0] SECOND_COUNT,
  input wire logic [23:0] FRACTION_COUNT,
  input wire logic signed [7:0] TIME_CTRL_OFFSET,
  // Frame word stream.
  output logic [15:0] FRAME_WORD,
  output logic FRAME_VALID,
  output logic FRAME_LAST,
  input wire logic FRAME_READY,
  // Flags.
  output logic [127:0] UNIT_NAME,
  output logic EXTERNAL_TIME_VALID,
  output logic TIME_QUALITY_FLAG,
  output logic MEASUREMENT_ENABLED_FLAG,
  output logic [3:0] TRIGGER_REASON,
  output logic FRAME_TRIGGER
);
  // Wraps a corrected angle back into the half-open span of one turn.
  function automatic logic [15:0] wrap_ang(input logic [15:0] a,
                                          input logic [15:0] o);
    logic signed [16:0] s;
    s = 17'(signed'(a)) + 17'(signed'(o));
    if (s > SFC_ANG_HALF) s = s - SFC_ANG_FULL;
    else if (s <= -SFC_ANG_HALF) s = s + SFC_ANG_FULL;
    return s[15:0];
  endfunction

  // Check value over one 16-bit word, high byte first.
  function automatic logic [15:0] crc_word(input logic [15:0] c,
                                          input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ SFC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Pin synchronisers: three stages, accepted once stages two and three
  // agree so a single metastable sample never reaches the flags.
  logic [1:0][2:0] pin_ff, nxt_pin;
  logic [1:0] pin_ok_ff, nxt_pin_ok;
  always_comb begin
    nxt_pin[0] = {pin_ff[0][1:0], EXT_TIME_LOCK};
    nxt_pin[1] = {pin_ff[1][1:0], EXT_TIME_ACCURATE};
    nxt_pin_ok = pin_ok_ff;
    for (int k = 0; k < 2; k++) begin
      if (pin_ff[k][1] == pin_ff[k][2]) nxt_pin_ok[k] = pin_ff[k][2];
    end
  end

  // Flag group: time validity, enables and trigger equations.
  logic ext_ff, nxt_ext, tq_ff, nxt_tq, en_ff, nxt_en;
  logic [3:0] rsn_ff, nxt_rsn;
  logic trig_ff, nxt_trig;
  logic [$clog2(HOLD_CYCLES+1)-1:0] hold_ff, nxt_hold;
  logic [127:0] name_ff, nxt_name;
  always_comb begin
    nxt_ext = pin_ok_ff[0];
    nxt_tq = pin_ok_ff[0] && pin_ok_ff[1];
    nxt_en = DEVICE_ENABLED && SYNCHROPHASOR_GLOBAL_ENABLE;
    nxt_name = STATION_NAME;
    for (int k = 0; k < 4; k++) begin
      nxt_rsn[k] = |(TRIGGER_TERMS[k] & TRIGGER_MASK[k]);
    end
    // A new reason pattern restarts the hold so the far end can read it.
    nxt_hold = hold_ff;
    if (nxt_rsn != rsn_ff && nxt_rsn != 4'h0) begin
      nxt_hold = $bits(hold_ff)'(HOLD_CYCLES);
    end else if (hold_ff != '0) begin
      nxt_hold = hold_ff - 1'b1;
    end
    nxt_trig = (|nxt_rsn) || (hold_ff != '0);
  end

  // Frame pacing: base period counter and a rate divider.
  logic [$clog2(BASE_CYCLES)-1:0] base_ff, nxt_base;
  logic [3:0] div_ff, nxt_div, div_end;
  logic tick;
  always_comb begin
    case (FRAME_RATE_SELECT)
      SFC_RATE_1: div_end = SFC_DIV_1;
      SFC_RATE_2: div_end = SFC_DIV_2;
      SFC_RATE_5: div_end = SFC_DIV_5;
      default: div_end = SFC_DIV_10;
    endcase
    nxt_base = base_ff + 1'b1;
    nxt_div = div_ff;
    tick = 1'b0;
    if (base_ff == $bits(base_ff)'(BASE_CYCLES - 1)) begin
      nxt_base = '0;
      nxt_div = div_ff + 1'b1;
      if (div_ff >= div_end - 1'b1) begin
        nxt_div = '0;
        tick = 1'b1;
      end
    end
  end

  // Snapshot taken in one cycle so every field shares one time stamp.
  logic [9:0][15:0] mag_ff, nxt_mag, ang_ff, nxt_ang;
  logic [3:0][31:0] an_ff, nxt_an;
  logic [15:0] dsw_ff, nxt_dsw, fd_ff, nxt_fd, fr_ff, nxt_fr, stw_ff;
  logic [15:0] nxt_stw, id_ff, nxt_id, size_ff, nxt_size;
  logic [31:0] soc_ff, nxt_soc;
  logic [23:0] frac_ff, nxt_frac;
  logic [9:0] use_ff, nxt_use;
  logic [2:0] na_ff, nxt_na;
  logic nd_ff, nxt_nd, capture;
  sfc_phsel_type vsel_ff, nxt_vsel;
  logic [15:0] nph;
  always_comb begin
    nxt_mag = mag_ff;
    nxt_ang = ang_ff;
    nxt_an = an_ff;
    nxt_dsw = dsw_ff;
    nxt_fd = fd_ff;
    nxt_fr = fr_ff;
    nxt_stw = stw_ff;
    nxt_id = id_ff;
    nxt_soc = soc_ff;
    nxt_frac = frac_ff;
    nxt_use = use_ff;
    nxt_na = na_ff;
    nxt_nd = nd_ff;
    nxt_vsel = vsel_ff;
    nxt_size = size_ff;
    nph = '0;
    if (capture) begin
      nxt_use = '0;
      case (VOLTAGE_PHASOR_SELECT)
        SFC_PH_POS: nxt_use[0] = 1'b1;
        SFC_PH_ALL: nxt_use[4:0] = {SYNC_INPUT_PRESENT, 4'hF};
        default: nxt_use[4:0] = 5'h00;
      endcase
      case (CURRENT_PHASOR_SELECT)
        SFC_PH_POS: nxt_use[5] = 1'b1;
        SFC_PH_ALL: nxt_use[9:5] = 5'h1F;
        default: nxt_use[9:5] = 5'h00;
      endcase
      for (int k = 0; k < 10; k++) begin
        nxt_mag[k] = PHASOR_MAG[k];
        nxt_ang[k] = wrap_ang(PHASOR_ANG[k], (k < 5) ?
          VOLTAGE_ANGLE_OFFSET : CURRENT_ANGLE_OFFSET);
        nph = nph + 16'(nxt_use[k]);
      end
      nxt_an = ANALOG_SLOT;
      nxt_na = (ANALOG_VALUE_COUNT > SFC_AN_MAX) ? SFC_AN_MAX :
        ANALOG_VALUE_COUNT;
      nxt_nd = STATUS_WORD_COUNT;
      nxt_dsw = STATUS_SOURCE;
      nxt_fd = FREQ_DEVIATION;
      nxt_fr = FREQ_RATE;
      nxt_id = UNIT_IDENTIFIER;
      nxt_vsel = VOLTAGE_PHASOR_SELECT;
      // Decoded extensions only move the stamp when enabled.
      nxt_soc = (TIME_EXTENSION_SELECT == SFC_TEXT_STD) ?
        SECOND_COUNT + 32'(TIME_CTRL_OFFSET) : SECOND_COUNT;
      nxt_frac = FRACTION_COUNT;
      nxt_stw = 16'h0000;
      nxt_stw[SFC_STAT_SYNC_ERR] = !tq_ff;
      nxt_stw[SFC_STAT_TRIG] = trig_ff;
      nxt_stw[3:0] = rsn_ff;
      nxt_size = SFC_FIXED_BYTES + SFC_FREQ_BYTES
        + 16'(nph * SFC_PH_BYTES) + 16'(nxt_na) * SFC_AN_BYTES
        + (nxt_nd ? SFC_DSW_BYTES : 16'h0000);
    end
  end

  // Emission: walks the frame one word per accepted push.
  sfc_state_type st_ff, nxt_st;
  logic [3:0] idx_ff, nxt_idx;
  logic sub_ff, nxt_sub;
  logic [15:0] crc_ff, nxt_crc, word;
  logic push, offer, last;
  sfc_stream_if #(.W(17)) f_in ();
  sfc_stream_if #(.W(17)) f_out ();
  always_comb begin
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    nxt_sub = sub_ff;
    nxt_crc = crc_ff;
    word = 16'h0000;
    offer = 1'b0;
    last = 1'b0;
    // A tick mid-frame is dropped; the next tick starts a fresh frame.
    capture = (st_ff == SFC_IDLE) && tick && en_ff;
    case (st_ff)
      SFC_IDLE: begin
        if (capture) begin
          nxt_st = SFC_HEAD;
          nxt_idx = '0;
          nxt_crc = SFC_CRC_INIT;
        end
      end
      SFC_HEAD: begin
        offer = 1'b1;
        case (idx_ff)
          4'h0: word = SFC_SYNC_WORD;
          4'h1: word = size_ff;
          4'h2: word = id_ff;
          4'h3: word = soc_ff[31:16];
          4'h4: word = soc_ff[15:0];
          4'h5: word = {8'h00, frac_ff[23:16]};
          4'h6: word = frac_ff[15:0];
          default: word = stw_ff;
        endcase
      end
      SFC_PHAS: begin
        offer = use_ff[idx_ff];
        word = sub_ff ? ang_ff[idx_ff] : mag_ff[idx_ff];
      end
      SFC_FREQ: begin
        offer = 1'b1;
        word = idx_ff[0] ? fr_ff : fd_ff;
      end
      SFC_ANLG: begin
        offer = 1'b1;
        word = idx_ff[0] ? an_ff[idx_ff[2:1]][15:0] :
          an_ff[idx_ff[2:1]][31:16];
      end
      SFC_STAT: begin
        offer = 1'b1;
        word = dsw_ff;
      end
      SFC_CRC: begin
        offer = 1'b1;
        word = crc_ff;
        last = 1'b1;
      end
      default: nxt_st = SFC_IDLE;
    endcase
    push = offer && f_in.ready;
    if (push && st_ff != SFC_CRC) nxt_crc = crc_word(crc_ff, word);
    // Advance on every push, and over unselected phasor slots.
    if (push || (st_ff == SFC_PHAS && !offer)) begin
      nxt_idx = idx_ff + 1'b1;
      case (st_ff)
        SFC_HEAD: begin
          if (idx_ff == SFC_HEAD_LAST) begin
            nxt_st = SFC_PHAS;
            nxt_idx = '0;
            nxt_sub = 1'b0;
          end
        end
        SFC_PHAS: begin
          nxt_idx = idx_ff;
          nxt_sub = offer && !sub_ff;
          if (nxt_sub == 1'b0) begin
            nxt_idx = idx_ff + 1'b1;
            if (idx_ff == SFC_PH_COUNT - 1'b1) begin
              nxt_st = SFC_FREQ;
              nxt_idx = '0;
            end
          end
        end
        SFC_FREQ, SFC_ANLG: begin
          if ((st_ff == SFC_FREQ && idx_ff[0]) ||
              (st_ff == SFC_ANLG && nxt_idx == {na_ff, 1'b0})) begin
            nxt_idx = '0;
            if (st_ff == SFC_FREQ && na_ff != '0) nxt_st = SFC_ANLG;
            else nxt_st = nd_ff ? SFC_STAT : SFC_CRC;
          end
        end
        SFC_STAT: nxt_st = SFC_CRC;
        default: nxt_st = SFC_IDLE;
      endcase
    end
  end
  assign f_in.valid = offer;
  assign f_in.data = {last, word};

  sfc_fifo #(.W(17), .D(FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .in_s(f_in),
    .out_s(f_out)
  );

  // Output stage keeps the stream ports on flip-flops.
  logic [16:0] out_ff, nxt_out;
  logic outv_ff, nxt_outv;
  always_comb begin
    f_out.ready = !outv_ff || FRAME_READY;
    nxt_out = out_ff;
    nxt_outv = outv_ff;
    if (f_out.ready) begin
      nxt_outv = f_out.valid;
      nxt_out = f_out.data;
    end
  end

  // All state registers of the block except those inside the FIFO.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_ff <= '0;
      pin_ok_ff <= '0;
      ext_ff <= 1'b0;
      tq_ff <= 1'b0;
      en_ff <= 1'b0;
      rsn_ff <= 4'h0;
      trig_ff <= 1'b0;
      hold_ff <= '0;
      name_ff <= '0;
      base_ff <= '0;
      div_ff <= 4'h0;
      mag_ff <= '0;
      ang_ff <= '0;
      an_ff <= '0;
      dsw_ff <= 16'h0000;
      fd_ff <= 16'h0000;
      fr_ff <= 16'h0000;
      stw_ff <= 16'h0000;
      id_ff <= 16'h0000;
      size_ff <= 16'h0000;
      soc_ff <= 32'h0000_0000;
      frac_ff <= 24'h00_0000;
      use_ff <= '0;
      na_ff <= 3'h0;
      nd_ff <= 1'b0;
      vsel_ff <= SFC_PH_NONE;
      st_ff <= SFC_IDLE;
      idx_ff <= 4'h0;
      sub_ff <= 1'b0;
      crc_ff <= SFC_CRC_INIT;
      out_ff <= '0;
      outv_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      pin_ok_ff <= nxt_pin_ok;
      ext_ff <= nxt_ext;
      tq_ff <= nxt_tq;
      en_ff <= nxt_en;
      rsn_ff <= nxt_rsn;
      trig_ff <= nxt_trig;
      hold_ff <= nxt_hold;
      name_ff <= nxt_name;
      base_ff <= nxt_base;
      div_ff <= nxt_div;
      mag_ff <= nxt_mag;
      ang_ff <= nxt_ang;
      an_ff <= nxt_an;
      dsw_ff <= nxt_dsw;
      fd_ff <= nxt_fd;
      fr_ff <= nxt_fr;
      stw_ff <= nxt_stw;
      id_ff <= nxt_id;
      size_ff <= nxt_size;
      soc_ff <= nxt_soc;
      frac_ff <= nxt_frac;
      use_ff <= nxt_use;
      na_ff <= nxt_na;
      nd_ff <= nxt_nd;
      vsel_ff <= nxt_vsel;
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
      sub_ff <= nxt_sub;
      crc_ff <= nxt_crc;
      out_ff <= nxt_out;
      outv_ff <= nxt_outv;
    end
  end

  assign FRAME_WORD = out_ff[15:0];
  assign FRAME_LAST = out_ff[16];
  assign FRAME_VALID = outv_ff;
  assign UNIT_NAME = name_ff;
  assign EXTERNAL_TIME_VALID = ext_ff;
  assign TIME_QUALITY_FLAG = tq_ff;
  assign MEASUREMENT_ENABLED_FLAG = en_ff;
  assign TRIGGER_REASON = rsn_ff;
  assign FRAME_TRIGGER = trig_ff;

  // Checks on the framer's own behaviour.
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  sequence head_push(int n);
    push && st_ff == SFC_HEAD && idx_ff == 4'(n);
  endsequence
  sequence ph_push;
    push && st_ff == SFC_PHAS;
  endsequence
  enable_flag_a: assert property (
    (DEVICE_ENABLED && SYNCHROPHASOR_GLOBAL_ENABLE)[*2] |=>
    MEASUREMENT_ENABLED_FLAG) else $error("enable flag missing");
  quality_ext_a: assert property (
    TIME_QUALITY_FLAG |-> EXTERNAL_TIME_VALID)
    else $error("quality without external time");
  sync_head_a: assert property (
    head_push(0) |-> word == SFC_SYNC_WORD) else $error("bad sync word");
  stat_trig_a: assert property (
    capture |=> stw_ff[3:0] == $past(TRIGGER_REASON) &&
    stw_ff[SFC_STAT_TRIG] == $past(FRAME_TRIGGER))
    else $error("trigger bits not in status");
  volt_none_a: assert property (
    ph_push and (vsel_ff == SFC_PH_NONE) |-> idx_ff >= SFC_PH_V_COUNT)
    else $error("voltage sent while none");
  volt_pos_a: assert property (
    ph_push and (vsel_ff == SFC_PH_POS) and (idx_ff < SFC_PH_V_COUNT)
    |-> idx_ff == 4'h0) else $error("extra voltage sent");
  polar_pair_a: assert property (
    ph_push and (sub_ff == 1'b0) |=> st_ff == SFC_PHAS && sub_ff &&
    idx_ff == $past(idx_ff)) else $error("angle not after magnitude");
  trig_hold_a: assert property (
    $rose(|TRIGGER_REASON) |=> FRAME_TRIGGER[*3])
    else $error("frame trigger not held");
  capture_go_a: assert property (
    capture |=> st_ff == SFC_HEAD && idx_ff == 4'h0 ##1 st_ff != SFC_IDLE)
    else $error("capture did not start frame");
  stamp_none_a: assert property (
    capture && TIME_EXTENSION_SELECT == SFC_TEXT_NONE |=>
    soc_ff == $past(SECOND_COUNT)) else $error("stamp moved while none");
endmodule // sfc_framer

// ### tb/sfc_sink.sv
/*
  Data concentrator stand-in that drains the frame word stream.
  Assumes the framer's clock and active low reset.
*/
module sfc_sink (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Frame stream.
  input wire logic [15:0] word,
  input wire logic valid,
  input wire logic last,
  output logic ready,
  // Pacing and frame end.
  input wire logic slow,
  output logic got_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] q[$]; // Words taken, oldest first.
  logic [1:0] ph_ff; // Stall phase counter.
  // A slow sink takes one word in four, so the FIFO backs up.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 2'h0;
      got_last <= 1'b0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
      got_last <= valid && ready && last;
      if (valid && ready) q.push_back(word);
    end
  end
  assign ready = rst_n && (!slow || ph_ff == 2'h3);
endmodule // sfc_sink

// ### tb/sfc_framer_tb.sv
/*
  Self-checking bench for the frame content block.
  Assumes short base and hold counts so that frames come quickly.
*/
module sfc_framer_tb;
  import sfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 40;
  localparam int HOLD = 8;
  logic clk = 0, rst_n = 0, nsw, gen, den, vs_here, lock, acc, slow, gl;
  logic [127:0] name, uname;
  logic [15:0] uid, fdev, frate, ssrc, fw;
  sfc_phsel_type vsel, isel;
  logic signed [15:0] voff, ioff;
  logic [2:0] nana;
  sfc_rate_type rate;
  sfc_text_type text;
  logic [9:0][15:0] mag, ang;
  logic [3:0][31:0] an;
  logic [3:0][15:0] terms, mask;
  logic [31:0] soc;
  logic [23:0] frac;
  logic signed [7:0] toff;
  logic fv, fl, fr, etv, tq, mef, ftrig;
  logic [3:0] reason;
  int err_total = 0, comparisons = 0;
  always #5 clk = ~clk;
  sfc_framer #(.BASE_CYCLES(BASE), .HOLD_CYCLES(HOLD), .FIFO_DEPTH(8)) uut (
    .SYS_CLK(clk), .RESET_N(rst_n), .STATION_NAME(name),
    .UNIT_IDENTIFIER(uid), .VOLTAGE_PHASOR_SELECT(vsel),
    .CURRENT_PHASOR_SELECT(isel), .VOLTAGE_ANGLE_OFFSET(voff),
    .CURRENT_ANGLE_OFFSET(ioff), .ANALOG_VALUE_COUNT(nana),
    .STATUS_WORD_COUNT(nsw), .FRAME_RATE_SELECT(rate),
    .TIME_EXTENSION_SELECT(text), .SYNCHROPHASOR_GLOBAL_ENABLE(gen),
    .DEVICE_ENABLED(den), .PHASOR_MAG(mag), .PHASOR_ANG(ang),
    .SYNC_INPUT_PRESENT(vs_here), .FREQ_DEVIATION(fdev), .FREQ_RATE(frate),
    .ANALOG_SLOT(an), .STATUS_SOURCE(ssrc), .TRIGGER_TERMS(terms),
    .TRIGGER_MASK(mask), .EXT_TIME_LOCK(lock), .EXT_TIME_ACCURATE(acc),
    .SECOND_COUNT(soc), .FRACTION_COUNT(frac), .TIME_CTRL_OFFSET(toff),
    .FRAME_WORD(fw), .FRAME_VALID(fv), .FRAME_LAST(fl), .FRAME_READY(fr),
    .UNIT_NAME(uname), .EXTERNAL_TIME_VALID(etv), .TIME_QUALITY_FLAG(tq),
    .MEASUREMENT_ENABLED_FLAG(mef), .TRIGGER_REASON(reason),
    .FRAME_TRIGGER(ftrig));
  sfc_sink sink (.clk(clk), .rst_n(rst_n), .word(fw), .valid(fv),
    .last(fl), .ready(fr), .slow(slow), .got_last(gl));
  // Compares one value and reports a difference at once.
  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // Inputs always move one nanosecond after the rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Waits, under a bound, for the end of the next frame.
  task automatic wait_last();
    int i;
    i = 0;
    step(1);
    while (gl !== 1'b1 && i < 3000) begin
      step(1);
      i++;
    end
    check(i < 3000, 1);
  endtask
  // The first frame may predate a settings change, so it is discarded.
  task automatic grab();
    wait_last();
    sink.q.delete();
    wait_last();
  endtask
  function automatic logic pick(sfc_phsel_type m, int j, logic here);
    return m == SFC_PH_ALL ? (j != 4 || here) : (m == SFC_PH_POS && j == 0);
  endfunction
  // Builds the whole expected frame and compares it word by word.
  task automatic frame_check();
    logic [15:0] e[$];
    logic [15:0] c;
    logic [31:0] s;
    step(8);
    grab();
    s = soc + ((text == SFC_TEXT_STD) ? 32'(toff) : 32'h0);
    e = '{16'hAA01, 16'h0, uid, s[31:16], s[15:0], {8'h0, frac[23:16]},
      frac[15:0], {2'b0, !acc, 13'h0}};
    for (int k = 0; k < 10; k++) begin
      if (pick(k < 5 ? vsel : isel, k % 5,
          k > 4 || vs_here)) begin
        e.push_back(mag[k]);
        e.push_back(ang[k] + (k < 5 ? voff : ioff));
      end
    end
    e.push_back(fdev);
    e.push_back(frate);
    for (int j = 0; j < nana; j++) begin
      e.push_back(an[j][31:16]);
      e.push_back(an[j][15:0]);
    end
    if (nsw) e.push_back(ssrc);
    e[1] = 16'(2 * e.size() + 2);
    c = 16'hFFFF;
    foreach (e[i]) for (int b = 15; b >= 0; b--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ e[i][b]) ? 16'h1021 : 16'h0);
    e.push_back(c);
    check(sink.q.size(), e.size());
    foreach (e[i]) check(sink.q[i], e[i]);
  endtask
  // Time source and enable flags, and the name copy.
  task automatic flag_test();
    acc = 1'b0;
    step(8);
    check({etv, tq}, 2'b10);
    lock = 1'b0;
    step(8);
    check({etv, tq}, 2'b00);
    lock = 1'b1;
    acc = 1'b1;
    step(8);
    check(tq, 1);
    den = 1'b0;
    step(2);
    check(mef, 0);
    den = 1'b1;
    gen = 1'b0;
    step(2);
    check(mef, 0);
    gen = 1'b1;
    step(2);
    check(mef, 1);
    check(uname, name);
  endtask
  // A reason reaches the header status word; a one-cycle reason keeps the trigger up.
  task automatic trig_test();
    terms[2] = 16'h0001;
    step(2);
    check(reason, 4'h4);
    grab();
    check(sink.q[7], 16'h0804);
    terms[2] = 16'h0000;
    step(HOLD + 4);
    terms[1] = 16'h0001;
    step(1);
    terms[1] = 16'h0000;
    step(4);
    check({reason, ftrig}, 5'h01);
    step(HOLD + 4);
    check(ftrig, 0);
  endtask
  // Frame spacing for all four rates; the base period leaves room for a
  // whole empty frame even at the fastest rate.
  task automatic rate_test();
    int div[4] = '{10, 5, 2, 1};
    time t0;
    vsel = SFC_PH_NONE;
    isel = SFC_PH_NONE;
    nana = 3'h0;
    slow = 1'b0;
    for (int r = 0; r < 4; r++) begin
      rate = sfc_rate_type'(r);
      grab();
      t0 = $time;
      wait_last();
      check(32'(($time - t0) / 10), 32'(BASE * div[r]));
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence: every selection pair, then triggers and rates.
  initial begin
    name = "FEEDER TEST UNIT";
    uid = 16'hFFFE;
    {voff, ioff, toff} = {16'h0010, 16'h0020, 8'h03};
    {nana, nsw, vs_here, slow} = '0;
    rate = SFC_RATE_1;
    text = SFC_TEXT_NONE;
    vsel = SFC_PH_NONE;
    isel = SFC_PH_NONE;
    {gen, den, lock, acc} = 4'hF;
    {fdev, frate, ssrc} = {16'h0123, 16'h0456, 16'hA5C3};
    {soc, frac} = {32'h1234_5678, 24'h9A_BCDE};
    for (int k = 0; k < 10; k++) begin
      mag[k] = 16'(16'h1000 + k);
      ang[k] = 16'(16'h0100 * k);
    end
    for (int j = 0; j < 4; j++) begin
      an[j] = 32'(32'h3F80_0000 + j);
      terms[j] = 16'h0000;
      mask[j] = 16'hFFFF;
    end
    step(12);
    rst_n = 1'b1;
    flag_test();
    for (int v = 0; v < 3; v++) begin
      for (int i = 0; i < 3; i++) begin
        vsel = sfc_phsel_type'(v);
        isel = sfc_phsel_type'(i);
        nana = 3'((3 * v + i) % 5);
        nsw = 1'(i == 1);
        vs_here = 1'(v != 2 || i != 0);
        text = sfc_text_type'(i % 2);
        acc = 1'(v != 1);
        slow = 1'(i == 2);
        frame_check();
      end
    end
    acc = 1'b1;
    trig_test();
    rate_test();
    conclude();
  end
  // Cuts a hang short well above the expected run length.
  initial begin
    #600_000;
    err_total++;
    conclude();
  end
endmodule // sfc_framer_tb
